// >>> common/ppoc_consts.svh
// Purpose: Constants for the port power and over-current control block.
// Assumes: Core clock of 25 MHz; sample tick of 1 us.
// Notes: Times are kept in their own unit; counts are derived from them.
`ifndef PPOC_CONSTS_SVH
`define PPOC_CONSTS_SVH

`define PPOC_NPORTS 2
`define PPOC_CLK_MHZ 25
`define PPOC_TICK_NS 1000
`define PPOC_TICK_CYC (`PPOC_CLK_MHZ * `PPOC_TICK_NS / 1000)
`define PPOC_TICKS_PER_MS (1000000 / `PPOC_TICK_NS)
`define PPOC_OCS_SINGLE_MS 5
`define PPOC_OCS_DOUBLE_MS 20
`define PPOC_BLANK_MS 1
`define PPOC_OCS_SINGLE_TICKS (`PPOC_OCS_SINGLE_MS * `PPOC_TICKS_PER_MS)
`define PPOC_OCS_DOUBLE_TICKS (`PPOC_OCS_DOUBLE_MS * `PPOC_TICKS_PER_MS)
`define PPOC_BLANK_TICKS (`PPOC_BLANK_MS * `PPOC_TICKS_PER_MS)

`define PPOC_REG_CTRL 8'h00
`define PPOC_REG_PWR_EN 8'h04
`define PPOC_REG_STATUS 8'h08
`define PPOC_REG_MASK 8'h0c
`define PPOC_REG_PIN_STATE 8'h10

`define PPOC_CTRL_GANG_BIT 0
`define PPOC_PIN_COMMON_BIT 2
`define PPOC_CTRL_RST 1'h0
`define PPOC_PWR_EN_RST 2'h0
`define PPOC_MASK_RST 2'h0

`define PPOC_RESP_OKAY 2'h0
`define PPOC_RESP_DECERR 2'h3

`endif

// >>> common/ppoc_pkg.sv
// Purpose: Types for the port power and over-current control block.
// Assumes: Constants come from the shared header.
// Notes: Each module keeps all of its state in one packed struct.
`include "ppoc_consts.svh"

package ppoc_pkg;

   typedef enum logic [5:0] {
      PPOC_SEL_CTRL = 6'h01,
      PPOC_SEL_PWR_EN = 6'h02,
      PPOC_SEL_STATUS = 6'h04,
      PPOC_SEL_MASK = 6'h08,
      PPOC_SEL_PIN = 6'h10,
      PPOC_SEL_NONE = 6'h20
   } ppoc_sel_t;

   typedef struct packed {
      logic prev_low;
      logic first_seen;
      logic [15:0] run_cnt;
      logic [15:0] win_cnt;
      logic [15:0] blank_cnt;
      logic oc_event;
   } ppoc_det_st_t;

   typedef struct packed {
      logic [`PPOC_NPORTS-1:0] sync1_port;
      logic [`PPOC_NPORTS-1:0] sync2_port;
      logic sync1_com;
      logic sync2_com;
      logic [4:0] div_cnt;
      logic tick;
      logic gang;
      logic [`PPOC_NPORTS-1:0] pwr_en;
      logic [`PPOC_NPORTS-1:0] status;
      logic [`PPOC_NPORTS-1:0] mask;
      logic irq;
      logic [`PPOC_NPORTS-1:0] port_oe_n;
      logic [`PPOC_NPORTS-1:0] port_pu;
      logic com_oe_n;
      logic com_pu;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ppoc_top_st_t;

endpackage : ppoc_pkg

// >>> common/ppoc_det_if.sv
// Purpose: Link between the control logic and one over-current detector.
// Assumes: Both ends run on clk_sys.
// Notes: The control end drives enable, tick and the synchronised pin level.
interface ppoc_det_if;
   logic enable;
   logic tick;
   logic pin_low;
   logic oc_event;
   logic in_low;

   modport det (
      input enable,
      input tick,
      input pin_low,
      output oc_event,
      output in_low
   );

   modport ctl (
      output enable,
      output tick,
      output pin_low,
      input oc_event,
      input in_low
   );
endinterface : ppoc_det_if

// >>> logic/ppoc_det.sv
// Purpose: Over-current filter for one sense pin.
// Assumes: pin_low is already synchronised; tick is a one-cycle 1 us pulse.
// Notes: oc_event is a one-cycle pulse from a flip-flop.
`include "ppoc_consts.svh"

module ppoc_det #(
   parameter logic [15:0] SINGLE_TICKS = 16'(`PPOC_OCS_SINGLE_TICKS),
   parameter logic [15:0] DOUBLE_TICKS = 16'(`PPOC_OCS_DOUBLE_TICKS),
   parameter logic [15:0] BLANK_TICKS = 16'(`PPOC_BLANK_TICKS)
) (
   input wire logic clk_sys,
   input wire logic resetn,
   ppoc_det_if.det bus
);

   ppoc_pkg::ppoc_det_st_t s;
   ppoc_pkg::ppoc_det_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.oc_event = 1'b0;
      if (!bus.enable) begin
         // Power off: forget all history so the next enable starts clean.
         next_s = '0;
         next_s.blank_cnt = BLANK_TICKS;
      end else if (bus.tick) begin
         if (s.blank_cnt != 16'h0) begin
            // Lows while the port powers up are ignored.
            next_s.blank_cnt = s.blank_cnt - 16'h1;
            next_s.prev_low = 1'b0;
            next_s.run_cnt = 16'h0;
         end else begin
            if (bus.pin_low) begin
               next_s.run_cnt = s.run_cnt + 16'h1;
               if (next_s.run_cnt >= SINGLE_TICKS) begin
                  next_s.oc_event = 1'b1;
               end
               if (!s.prev_low) begin
                  if (s.first_seen) begin
                     next_s.oc_event = 1'b1;
                  end else begin
                     next_s.first_seen = 1'b1;
                     next_s.win_cnt = 16'h0;
                  end
               end
               next_s.prev_low = 1'b1;
            end else begin
               next_s.prev_low = 1'b0;
               next_s.run_cnt = 16'h0;
            end
            if (s.first_seen && !next_s.oc_event) begin
               // The window runs from the start of the first low group.
               next_s.win_cnt = s.win_cnt + 16'h1;
               if (next_s.win_cnt >= DOUBLE_TICKS) begin
                  next_s.first_seen = 1'b0;
                  next_s.win_cnt = 16'h0;
               end
            end
            if (next_s.oc_event) begin
               // A low that persists is reported again after a full single time.
               next_s.run_cnt = 16'h0;
               next_s.first_seen = 1'b0;
               next_s.win_cnt = 16'h0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign bus.oc_event = s.oc_event;
   assign bus.in_low = s.prev_low;

endmodule : ppoc_det

// >>> logic/ppoc_top.sv
// Purpose: Downstream port power control and over-current sense for a hub.
// Assumes: One clock; pins are open-drain with active-low output enables.
// Notes: Registers sit behind an AXI4-Lite slave; one level interrupt.
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`include "ppoc_consts.svh"

module ppoc_top #(
   parameter logic [15:0] OCS_SINGLE_TICKS = 16'(`PPOC_OCS_SINGLE_TICKS),
   parameter logic [15:0] OCS_DOUBLE_TICKS = 16'(`PPOC_OCS_DOUBLE_TICKS),
   parameter logic [15:0] BLANK_TICKS = 16'(`PPOC_BLANK_TICKS)
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`PPOC_NPORTS-1:0] port_power_sense_pin_in,
   output logic [`PPOC_NPORTS-1:0] port_power_sense_pin_out,
   output logic [`PPOC_NPORTS-1:0] port_power_sense_pin_oe_n,
   output logic [`PPOC_NPORTS-1:0] port_pullup_en,
   input wire logic common_power_sense_pin_in,
   output logic common_power_sense_pin_out,
   output logic common_power_sense_pin_oe_n,
   output logic common_pullup_en,
   output logic irq
);

   localparam int NP = `PPOC_NPORTS;

   localparam ppoc_pkg::ppoc_top_st_t TOP_RST = '{
      awready: 1'b1,
      wready: 1'b1,
      arready: 1'b1,
      gang: `PPOC_CTRL_RST,
      pwr_en: `PPOC_PWR_EN_RST,
      mask: `PPOC_MASK_RST,
      default: '0
   };

   ppoc_pkg::ppoc_top_st_t s;
   ppoc_pkg::ppoc_top_st_t next_s;
   logic [NP-1:0] det_event;
   logic [NP-1:0] det_in_low;
   logic [NP-1:0] det_enable;
   logic [NP-1:0] det_pin_low;

   // Register decode shared by the write and the read path.
   function automatic ppoc_pkg::ppoc_sel_t ppoc_decode(input logic [7:0] addr);
      ppoc_pkg::ppoc_sel_t sel;
      sel = ppoc_pkg::PPOC_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         unique case (addr)
            `PPOC_REG_CTRL: sel = ppoc_pkg::PPOC_SEL_CTRL;
            `PPOC_REG_PWR_EN: sel = ppoc_pkg::PPOC_SEL_PWR_EN;
            `PPOC_REG_STATUS: sel = ppoc_pkg::PPOC_SEL_STATUS;
            `PPOC_REG_MASK: sel = ppoc_pkg::PPOC_SEL_MASK;
            `PPOC_REG_PIN_STATE: sel = ppoc_pkg::PPOC_SEL_PIN;
            default: sel = ppoc_pkg::PPOC_SEL_NONE;
         endcase
      end
      return sel;
   endfunction : ppoc_decode

   // Each detector watches one pin; in ganged mode only detector 0 runs,
   // fed from the common pin.
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_det
         ppoc_det_if u_if ();

         assign det_enable[gi] = s.gang ? ((gi == 0) && s.pwr_en[0])
                                        : s.pwr_en[gi];
         assign det_pin_low[gi] = (s.gang && (gi == 0)) ? !s.sync2_com
                                                        : !s.sync2_port[gi];
         assign u_if.enable = det_enable[gi];
         assign u_if.tick = s.tick;
         assign u_if.pin_low = det_pin_low[gi];
         assign det_event[gi] = u_if.oc_event;
         assign det_in_low[gi] = u_if.in_low;

         ppoc_det #(
            .SINGLE_TICKS(OCS_SINGLE_TICKS),
            .DOUBLE_TICKS(OCS_DOUBLE_TICKS),
            .BLANK_TICKS(BLANK_TICKS)
         ) u_det (
            .clk_sys(clk_sys),
            .resetn(resetn),
            .bus(u_if.det)
         );
      end
   endgenerate

   always_comb begin
      logic [NP-1:0] ev;
      logic [NP-1:0] rd_clr;
      logic [NP-1:0] drive_on;
      ppoc_pkg::ppoc_sel_t wsel;
      ppoc_pkg::ppoc_sel_t rsel;
      ev = '0;
      rd_clr = '0;
      drive_on = '0;
      wsel = ppoc_pkg::PPOC_SEL_NONE;
      rsel = ppoc_pkg::PPOC_SEL_NONE;
      next_s = s;

      // Two-flop synchronisers on the sense pins.
      next_s.sync1_port = port_power_sense_pin_in;
      next_s.sync2_port = s.sync1_port;
      next_s.sync1_com = common_power_sense_pin_in;
      next_s.sync2_com = s.sync1_com;

      // Sample tick divider.
      next_s.tick = 1'b0;
      if (s.div_cnt == 5'(`PPOC_TICK_CYC - 1)) begin
         next_s.div_cnt = 5'h0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div_cnt = s.div_cnt + 5'h1;
      end

      // Write channel: address and data are taken in either order.
      if (s_axi_awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata;
         next_s.wstrb0 = s_axi_wstrb[0];
      end
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
         wsel = ppoc_decode(next_s.waddr);
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = (wsel == ppoc_pkg::PPOC_SEL_NONE) ? `PPOC_RESP_DECERR
                                                          : `PPOC_RESP_OKAY;
         if (next_s.wstrb0) begin
            unique case (wsel)
               ppoc_pkg::PPOC_SEL_CTRL: next_s.gang = next_s.wdata[`PPOC_CTRL_GANG_BIT];
               ppoc_pkg::PPOC_SEL_PWR_EN: next_s.pwr_en = next_s.wdata[NP-1:0];
               ppoc_pkg::PPOC_SEL_MASK: next_s.mask = next_s.wdata[NP-1:0];
               ppoc_pkg::PPOC_SEL_STATUS,
               ppoc_pkg::PPOC_SEL_PIN,
               ppoc_pkg::PPOC_SEL_NONE: begin
               end
            endcase
         end
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // Read channel.
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         rsel = ppoc_decode(s_axi_araddr);
         next_s.rvalid = 1'b1;
         next_s.rresp = `PPOC_RESP_OKAY;
         next_s.rdata = 32'h0;
         unique case (rsel)
            ppoc_pkg::PPOC_SEL_CTRL: next_s.rdata[`PPOC_CTRL_GANG_BIT] = s.gang;
            ppoc_pkg::PPOC_SEL_PWR_EN: next_s.rdata[NP-1:0] = s.pwr_en;
            ppoc_pkg::PPOC_SEL_STATUS: begin
               next_s.rdata[NP-1:0] = s.status;
               rd_clr = s.status;
            end
            ppoc_pkg::PPOC_SEL_MASK: next_s.rdata[NP-1:0] = s.mask;
            ppoc_pkg::PPOC_SEL_PIN: begin
               next_s.rdata[NP-1:0] = s.sync2_port;
               next_s.rdata[`PPOC_PIN_COMMON_BIT] = s.sync2_com;
               next_s.rdata[NP+1 +: NP] = det_in_low;
            end
            ppoc_pkg::PPOC_SEL_NONE: next_s.rresp = `PPOC_RESP_DECERR;
         endcase
      end
      next_s.arready = !next_s.rvalid;

      // In ganged mode the single detector speaks for every port.
      ev = s.gang ? {NP{det_event[0]}} : det_event;
      // A new event in the cycle of the clearing read still sets the bit.
      next_s.status = (s.status & ~rd_clr) | ev;
      next_s.irq = |(next_s.status & next_s.mask);

      // Pin drive: off drives low with the pull-up off, on releases the
      // driver and turns the pull-up on so the far side may pull low.
      // The new mode is used so that a mode write moves the pins at the same
      // edge as its write response, just like a power enable write.
      for (int i = 0; i < NP; i++) begin
         drive_on[i] = !next_s.gang && next_s.pwr_en[i];
      end
      next_s.port_oe_n = drive_on;
      next_s.port_pu = drive_on;
      next_s.com_oe_n = next_s.gang && next_s.pwr_en[0];
      next_s.com_pu = next_s.gang && next_s.pwr_en[0];
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= TOP_RST;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   // The pins only ever drive low; the released level comes from the pull-up.
   assign port_power_sense_pin_out = '0;
   assign common_power_sense_pin_out = 1'b0;
   assign port_power_sense_pin_oe_n = s.port_oe_n;
   assign port_pullup_en = s.port_pu;
   assign common_power_sense_pin_oe_n = s.com_oe_n;
   assign common_pullup_en = s.com_pu;
   assign irq = s.irq;

endmodule : ppoc_top

// >>> tb/ppoc_top_monitor.sv
// Purpose: Concurrent checks on the pins and interrupt of ppoc_top.
// Assumes: One clock domain; resetn is active low.
// Notes: Attached by the bind at the foot of this file.
`include "ppoc_consts.svh"

module ppoc_top_monitor (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic [`PPOC_NPORTS-1:0] port_power_sense_pin_out,
   input wire logic [`PPOC_NPORTS-1:0] port_power_sense_pin_oe_n,
   input wire logic [`PPOC_NPORTS-1:0] port_pullup_en,
   input wire logic common_power_sense_pin_out,
   input wire logic common_power_sense_pin_oe_n,
   input wire logic common_pullup_en,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_rel_start;
      $rose(port_power_sense_pin_oe_n[0]) && !irq;
   endsequence
   // Any bus activity may legally clear status or change the mask.
   sequence s_bus_idle;
      !s_axi_arvalid && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid && !s_axi_rvalid;
   endsequence

   a_drive_zero: assert property (
      port_power_sense_pin_out == '0 && !common_power_sense_pin_out)
      else $error("pin output data not low");
   a_port_pullup_pair: assert property (
      port_pullup_en == port_power_sense_pin_oe_n)
      else $error("port pull-up does not follow driver release");
   a_com_pullup_pair: assert property (
      common_pullup_en == common_power_sense_pin_oe_n)
      else $error("common pull-up does not follow driver release");
   a_gang_ports_held: assert property (
      common_power_sense_pin_oe_n |-> port_power_sense_pin_oe_n == '0)
      else $error("port pin released while common pin in use");
   a_pin_change_cause: assert property (
      $changed({port_power_sense_pin_oe_n, common_power_sense_pin_oe_n}) |-> $rose(s_axi_bvalid))
      else $error("pin drive changed without a register write");
   a_irq_sticky: assert property (
      s_bus_idle ##0 irq |=> irq)
      else $error("interrupt dropped without bus access");
   a_blank_quiet: assert property (
      s_rel_start |=> !irq [*8])
      else $error("interrupt right after power on");
   a_off_no_irq: assert property (
      $rose(irq) && !s_axi_bvalid |->
      $past(port_power_sense_pin_oe_n, 2) != '0 || $past(common_power_sense_pin_oe_n, 2))
      else $error("over-current raised with all pins off");
endmodule : ppoc_top_monitor

bind ppoc_top ppoc_top_monitor ppoc_top_monitor_inst (
   .clk_sys(clk_sys),
   .resetn(resetn),
   .s_axi_awvalid(s_axi_awvalid),
   .s_axi_wvalid(s_axi_wvalid),
   .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid),
   .s_axi_rvalid(s_axi_rvalid),
   .port_power_sense_pin_out(port_power_sense_pin_out),
   .port_power_sense_pin_oe_n(port_power_sense_pin_oe_n),
   .port_pullup_en(port_pullup_en),
   .common_power_sense_pin_out(common_power_sense_pin_out),
   .common_power_sense_pin_oe_n(common_power_sense_pin_oe_n),
   .common_pullup_en(common_pullup_en),
   .irq(irq)
);

// >>> tb/ppoc_switch_model.sv
// Purpose: External power switch or fuse circuit on the sense pins.
// Assumes: Bit 2 is the common pin of tied boards, bits 1:0 the port pins.
// Notes: A released pin with no pull-up toggles, so no stale level is read.
module ppoc_switch_model (
   input wire logic clk_sys,
   input wire logic [2:0] oe_n,
   input wire logic [2:0] pullup_en,
   input wire logic [2:0] fault,
   output logic [2:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog = 1'h0;
   always @(posedge clk_sys) begin
      tog <= !tog;
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (!oe_n[i]) begin
            pin[i] = 1'h0;
         end else if (fault[i]) begin
            pin[i] = 1'h0;
         end else begin
            // A fuse board has no switch delay: the pin is good once released.
            pin[i] = pullup_en[i] ? 1'h1 : tog;
         end
      end
   end
endmodule : ppoc_switch_model

// >>> tb/port_power_overcurrent_ctl_tb_top.sv
// Purpose: Self-checking bench for ppoc_top.
// Assumes: Shortened counts: single 10, double 40, blank 4 ticks.
// Notes: One tick is 25 clocks; pin levels come from the switch model.
`include "ppoc_consts.svh"

module port_power_overcurrent_ctl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 25;
   logic clk_sys, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, c_out, c_oe_n, c_pu, irq;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, p_out, oe_n, pu;
   logic [2:0] fault, pins;
   logic [3:0] wstrb;
   int bad_count = 0;
   int n_checks = 0;

   ppoc_top #(.OCS_SINGLE_TICKS(16'h000a), .OCS_DOUBLE_TICKS(16'h0028),
      .BLANK_TICKS(16'h0004)) ppoc_top_inst (.clk_sys(clk_sys), .resetn(resetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_power_sense_pin_in(pins[1:0]),
      .port_power_sense_pin_out(p_out), .port_power_sense_pin_oe_n(oe_n),
      .port_pullup_en(pu), .common_power_sense_pin_in(pins[2]),
      .common_power_sense_pin_out(c_out), .common_power_sense_pin_oe_n(c_oe_n),
      .common_pullup_en(c_pu), .irq(irq));
   ppoc_switch_model ppoc_switch_model_inst (.clk_sys(clk_sys), .oe_n({c_oe_n, oe_n}),
      .pullup_en({c_pu, pu}), .fault(fault), .pin(pins));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic got;
      got = 1'h0;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!got) begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         got = bvalid;
      end
      chk("bresp", er, bresp);
      bready <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
      input string nm);
      logic got;
      got = 1'h0;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!got) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'h0;
         got = rvalid;
      end
      chk(nm, ed, rdata);
      chk("rresp", er, rresp);
      rready <= 1'h0;
   endtask : rd

   task automatic ticks(input int n);
      repeat (n * TK) @(posedge clk_sys);
   endtask : ticks

   task automatic wait_irq(input int n);
      for (int i = 0; i < n * TK && irq !== 1'h1; i++) @(posedge clk_sys);
   endtask : wait_irq

   task automatic t_reset;
      chk("oe_n", 32'h0, {oe_n, c_oe_n});
      chk("pullup", 32'h0, {pu, c_pu, p_out, c_out});
      rd(`PPOC_REG_CTRL, 32'h0, `PPOC_RESP_OKAY, "ctrl");
      rd(`PPOC_REG_PWR_EN, 32'h0, `PPOC_RESP_OKAY, "pwr_en");
      rd(`PPOC_REG_MASK, 32'h0, `PPOC_RESP_OKAY, "mask");
      rd(8'h14, 32'h0, `PPOC_RESP_DECERR, "unmapped");
      wr(8'h14, 32'h3, `PPOC_RESP_DECERR);
      // A write with byte lane 0 off must leave the register alone.
      wstrb <= 4'he;
      wr(`PPOC_REG_MASK, 32'h3, `PPOC_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`PPOC_REG_MASK, 32'h0, `PPOC_RESP_OKAY, "mask_strb");
   endtask : t_reset

   task automatic t_enable;
      wr(`PPOC_REG_MASK, 32'h3, `PPOC_RESP_OKAY);
      wr(`PPOC_REG_PWR_EN, 32'h3, `PPOC_RESP_OKAY);
      chk("oe_n", 32'hf, {oe_n, pu});
      fault <= 3'h1;
      ticks(2);
      fault <= 3'h0;
      ticks(20);
      chk("irq", 32'h0, irq);
      rd(`PPOC_REG_PIN_STATE, 32'h3, `PPOC_RESP_OKAY, "pins");
   endtask : t_enable

   task automatic t_single;
      fault <= 3'h1;
      ticks(9);
      fault <= 3'h0;
      ticks(45);
      chk("irq", 32'h0, irq);
      fault <= 3'h1;
      ticks(8);
      chk("irq", 32'h0, irq);
      rd(`PPOC_REG_PIN_STATE, 32'ha, `PPOC_RESP_OKAY, "pins_low");
      wait_irq(5);
      chk("irq", 32'h1, irq);
      fault <= 3'h0;
      rd(`PPOC_REG_STATUS, 32'h1, `PPOC_RESP_OKAY, "status");
      @(posedge clk_sys);
      chk("irq", 32'h0, irq);
      rd(`PPOC_REG_STATUS, 32'h0, `PPOC_RESP_OKAY, "status");
   endtask : t_single

   task automatic t_double;
      fault <= 3'h2;
      ticks(2);
      fault <= 3'h0;
      ticks(10);
      chk("irq", 32'h0, irq);
      fault <= 3'h2;
      wait_irq(4);
      chk("irq", 32'h1, irq);
      fault <= 3'h0;
      wr(`PPOC_REG_MASK, 32'h0, `PPOC_RESP_OKAY);
      @(posedge clk_sys);
      chk("irq", 32'h0, irq);
      wr(`PPOC_REG_MASK, 32'h3, `PPOC_RESP_OKAY);
      @(posedge clk_sys);
      chk("irq", 32'h1, irq);
      rd(`PPOC_REG_STATUS, 32'h2, `PPOC_RESP_OKAY, "status");
   endtask : t_double

   task automatic t_clear;
      ticks(40);
      fault <= 3'h1;
      ticks(2);
      fault <= 3'h0;
      ticks(1);
      wr(`PPOC_REG_PWR_EN, 32'h2, `PPOC_RESP_OKAY);
      chk("oe_n", 32'ha, {oe_n, pu});
      wr(`PPOC_REG_PWR_EN, 32'h3, `PPOC_RESP_OKAY);
      ticks(6);
      fault <= 3'h1;
      ticks(2);
      fault <= 3'h0;
      ticks(6);
      chk("irq", 32'h0, irq);
   endtask : t_clear

   task automatic t_gang;
      wr(`PPOC_REG_PWR_EN, 32'h0, `PPOC_RESP_OKAY);
      wr(`PPOC_REG_CTRL, 32'h1, `PPOC_RESP_OKAY);
      wr(`PPOC_REG_PWR_EN, 32'h1, `PPOC_RESP_OKAY);
      chk("gang_pins", 32'h3, {oe_n, c_oe_n, c_pu});
      ticks(6);
      fault <= 3'h4;
      wait_irq(14);
      chk("irq", 32'h1, irq);
      fault <= 3'h0;
      rd(`PPOC_REG_STATUS, 32'h3, `PPOC_RESP_OKAY, "status");
      wr(`PPOC_REG_PWR_EN, 32'h0, `PPOC_RESP_OKAY);
      chk("c_oe_n", 32'h0, c_oe_n);
   endtask : t_gang

   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end

   initial begin
      resetn = 1'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, fault} = '0;
      wstrb = 4'hf;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'h1;
      t_reset();
      t_enable();
      t_single();
      t_double();
      t_clear();
      t_gang();
      wrap_up();
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      bad_count++;
      wrap_up();
   end
endmodule : port_power_overcurrent_ctl_tb_top
